// [rtl/i2s_switch_consts.vh]
// Constants for the serial audio input switch and its register file.
`ifndef I2S_SWITCH_CONSTS_VH
`define I2S_SWITCH_CONSTS_VH

// Register indexes; byte address is four times the index.
`define CTRL_IDX        14'h0FFF
`define STAT_IDX        14'h0001

// Control register layout and reset value.
`define CTRL_RST        16'h0000
`define CTRL_SEL_BIT    5
`define CTRL_DIS_BIT    7
`define CTRL_ENA3_BIT   13
`define CTRL_IMODE_BIT  15

// Status register layout.
`define ST_SEL_BIT      0
`define ST_WL_LSB       1
`define ST_WR_LSB       6
`define ST_BUSY_BIT     11
`define ST_START_BIT    12
`define ST_STOP_BIT     13
`define ST_DIV_BIT      14
`define ST_RAW_BIT      15

// Sample word geometry.
`define SAMPLE_MAX      5'h12
`define SAMPLE_MSB      5'h11

`endif

// [rtl/edge_sense.v]
// Registered sample of a synchronous pin with rise and fall pulses.
`timescale 1ns/1ps
module edge_sense (
   input  wire clk,                 // Core clock.
   input  wire rst_n,               // Synchronised reset, active low.
   input  wire d,                   // Pin level.
   output wire q,                   // Registered level.
   output wire rise,                // Rising pulse.
   output wire fall                 // Falling pulse.
);

   reg q_ff;
   reg prev_ff;

   // Two stages give a level and its previous value for edge compare.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_ff    <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         q_ff    <= d;
         prev_ff <= q_ff;
      end
   end

   assign q    = q_ff;
   assign rise = q_ff & ~prev_ff;
   assign fall = ~q_ff & prev_ff;

endmodule // edge_sense

// [rtl/i2s_input_switch_output.v]
// Serial audio input switch, one-period delay line, clock path and bus watch.
//
// Function
// R1 - Crystal mode halves the oscillator to give a clock of even duty.
// R2 - Bypass pin low selects the divided oscillator; board keeps it low.
// R3 - With an external master clock the bypass pin switches divider in or out.
// R4 - Test position skips the divider and passes the raw clock.
// R5 - Word select 0 marks the left word, 1 the right word.
// R6 - Samples are two's complement, most significant bit first.
// R7 - Left MSB goes out one bit clock after word select falls.
// R8 - Data changes on the falling bit clock and is taken on the rising one.
// R9 - Select bit 0 makes input 1 timing master, 1 makes input 2 master.
// R10 - Any width up to 18 bits is accepted; longer words are cut to 18.
// R11 - All three data outputs carry the selected data stream.
// R12 - Bit clock and word select outputs follow the selected input in phase.
// R13 - Each output sample leaves one sample period after it arrived.
// R14 - Disable bit floats the bit clock and word select outputs.
// R15 - Third data output is driven only while its enable bit is set.
// R16 - Control bus data must stay stable while its clock is high.
// R17 - Control bus clock must not exceed 100 kHz.
// R18 - Data falling with clock high is start; rising with clock high is stop.
// R19 - A control transfer may begin only while the bus is idle.
// R20 - Select, disable and enable bits sit in a write-only register at 0FFFH.
// R21 - Input 2 selected routes its clock, word select and data out.
`timescale 1ns/1ps
`include "i2s_switch_consts.vh"
module i2s_input_switch_output (
   input  wire        core_clk,                 // Core clock, 25 MHz.
   input  wire        rst_b,                    // Reset, active low, async.
   // Wishbone classic slave.
   input  wire        wb_cyc_i,                 // Bus cycle.
   input  wire        wb_stb_i,                 // Strobe.
   input  wire        wb_we_i,                  // Write enable.
   input  wire [15:0] wb_adr_i,                 // Byte address.
   input  wire [3:0]  wb_sel_i,                 // Byte lane selects.
   input  wire [31:0] wb_dat_i,                 // Write data.
   output wire [31:0] wb_dat_o,                 // Read data.
   output wire        wb_ack_o,                 // Acknowledge.
   // Clock path.
   input  wire        oscillator_sense_in,      // Oscillator or master clock.
   output wire        oscillator_drive_out,     // Amplifier drive back.
   input  wire        clock_divider_bypass_n,   // Low selects divided clock while test mode is low.
   input  wire        clock_test_mode,          // High passes raw clock.
   output wire        internal_clock_out,       // Clock fed to internal logic.
   // Serial audio inputs.
   input  wire        bit_clock_in_1,           // Input 1 bit clock.
   input  wire        word_select_in_1,         // Input 1 word select.
   input  wire        audio_data_in_1,          // Input 1 data.
   input  wire        bit_clock_in_2,           // Input 2 bit clock.
   input  wire        word_select_in_2,         // Input 2 word select.
   input  wire        audio_data_in_2,          // Input 2 data.
   // Serial audio outputs.
   output wire        bit_clock_out,            // Selected bit clock.
   output wire        bit_clock_out_oe_n,       // Low while driven.
   output wire        word_select_out,          // Selected word select.
   output wire        word_select_out_oe_n,     // Low while driven.
   output wire        audio_data_out_1,         // Delayed data 1.
   output wire        audio_data_out_1_oe_n,    // Low while driven.
   output wire        audio_data_out_2,         // Delayed data 2.
   output wire        audio_data_out_2_oe_n,    // Low while driven.
   output wire        audio_data_out_3,         // Delayed data 3.
   output wire        audio_data_out_3_oe_n,    // Low while driven.
   // Control bus lines, watched only.
   input  wire        ctl_scl_in,               // Control bus clock level.
   input  wire        ctl_sda_in                // Control bus data level.
);

   // Reset release flops; assertion is immediate, release is clocked.
   reg rst_meta_ff;
   reg rst_n_ff;

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   // Register file.
   reg  [15:0] ctrl_ff;
   reg         ack_ff;
   reg  [31:0] rdat_ff;
   reg         start_seen_ff;
   reg         stop_seen_ff;
   wire [13:0] reg_idx;
   wire        req;
   wire        wr_ctrl;
   wire        wr_stat;
   wire [15:0] status;

   assign reg_idx = wb_adr_i[15:2];
   assign req     = wb_cyc_i & wb_stb_i;
   // Writes land on the edge where the master samples ack high.
   assign wr_ctrl = req & ack_ff & wb_we_i & (reg_idx == `CTRL_IDX);
   assign wr_stat = req & ack_ff & wb_we_i & (reg_idx == `STAT_IDX);

   wire sel_in2;
   wire out_clk_dis;
   wire out3_ena;

   assign sel_in2     = ctrl_ff[`CTRL_SEL_BIT];
   assign out_clk_dis = ctrl_ff[`CTRL_DIS_BIT];
   assign out3_ena    = ctrl_ff[`CTRL_ENA3_BIT];

   // Ack follows a request by one cycle; unmapped reads give zero.
   always @(posedge core_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else begin
         ack_ff <= req & ~ack_ff;
         if (req & ~ack_ff & ~wb_we_i & (reg_idx == `STAT_IDX)) begin
            rdat_ff <= {16'h0000, status};
         end else begin
            rdat_ff <= 32'h00000000;
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   // Control register takes its two low byte lanes; reads give zero.
   always @(posedge core_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         ctrl_ff <= `CTRL_RST;
      end else if (wr_ctrl) begin  // R20
         if (wb_sel_i[0]) begin
            ctrl_ff[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            ctrl_ff[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // Clock path: divider, bypass pin and test multiplexer.
   wire osc_q;
   wire osc_rise;
   reg  osc_half_ff;
   reg  int_clk_ff;
   reg  osc_drive_ff;
   wire use_div;

   edge_sense u_osc (.clk(core_clk), .rst_n(rst_n_ff), .d(oscillator_sense_in), .q(osc_q), .rise(osc_rise), .fall());

   // Toggling on every rising edge halves the rate with even duty.
   always @(posedge core_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         osc_half_ff <= 1'b0;
      end else if (osc_rise) begin
         osc_half_ff <= ~osc_half_ff;  // R1
      end
   end

   // Test position wins over the bypass pin so clock phase is direct.
   assign use_div = ~clock_test_mode & ~clock_divider_bypass_n;  // R2 R3 R4

   always @(posedge core_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         int_clk_ff   <= 1'b0;
         osc_drive_ff <= 1'b1;
      end else begin
         int_clk_ff   <= use_div ? osc_half_ff : osc_q;  // R3 R4
         osc_drive_ff <= ~osc_q;
      end
   end

   assign internal_clock_out   = int_clk_ff;
   assign oscillator_drive_out = osc_drive_ff;

   // Input switch; every line of the master comes from one input.
   wire sel_bck;
   wire sel_ws;
   wire sel_din;

   assign sel_bck = sel_in2 ? bit_clock_in_2 : bit_clock_in_1;  // R9 R21
   assign sel_ws  = sel_in2 ? word_select_in_2 : word_select_in_1;  // R21
   assign sel_din = sel_in2 ? audio_data_in_2 : audio_data_in_1;  // R21

   wire bck_q;
   wire bck_rise;
   wire bck_fall;
   wire ws_q;
   wire din_q;

   edge_sense u_bck (.clk(core_clk), .rst_n(rst_n_ff), .d(sel_bck), .q(bck_q), .rise(bck_rise), .fall(bck_fall));

   // Word select and data get the same single stage as the bit clock.
   edge_sense u_ws (.clk(core_clk), .rst_n(rst_n_ff), .d(sel_ws), .q(ws_q), .rise(), .fall());

   edge_sense u_din (.clk(core_clk), .rst_n(rst_n_ff), .d(sel_din), .q(din_q), .rise(), .fall());

   // Outputs share the input stage delay, so they stay in phase.
   assign bit_clock_out   = bck_q;  // R12
   assign word_select_out = ws_q;  // R12

   // Receiver: bits taken on the rising bit clock, MSB first.
   reg  [17:0] rx_sh_ff;
   reg  [4:0]  rx_cnt_ff;
   reg         ws_prev_ff;
   reg  [17:0] held_left_ff;
   reg  [17:0] held_right_ff;
   reg  [4:0]  width_left_ff;
   reg  [4:0]  width_right_ff;
   reg  [17:0] tx_sh_ff;
   reg         dout_ff;
   reg  [17:0] nxt_rx_sh;
   wire [4:0]  rx_pos;
   wire [4:0]  done_width;
   wire        room;
   wire        boundary;

   assign room       = rx_cnt_ff < `SAMPLE_MAX;
   assign rx_pos     = `SAMPLE_MSB - rx_cnt_ff;
   assign done_width = room ? rx_cnt_ff + 5'h01 : `SAMPLE_MAX;  // R10
   // A change of word select seen at a rising edge ends the old word,
   // since that bit is still the last bit of the previous channel.
   assign boundary   = bck_rise & (ws_q != ws_prev_ff);

   // Bits beyond the eighteenth are dropped; short words stay left aligned.
   always @* begin
      nxt_rx_sh = rx_sh_ff;
      if (room) begin
         nxt_rx_sh[rx_pos] = din_q;  // R6 R10
      end
   end

   always @(posedge core_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rx_sh_ff       <= 18'h00000;
         rx_cnt_ff      <= 5'h00;
         ws_prev_ff     <= 1'b0;
         held_left_ff   <= 18'h00000;
         held_right_ff  <= 18'h00000;
         width_left_ff  <= 5'h00;
         width_right_ff <= 5'h00;
      end else if (boundary) begin
         rx_sh_ff   <= 18'h00000;
         rx_cnt_ff  <= 5'h00;
         ws_prev_ff <= ws_q;
         // Level 0 was the left word, level 1 the right word.
         if (!ws_prev_ff) begin  // R5
            held_left_ff  <= nxt_rx_sh;
            width_left_ff <= done_width;
         end else begin
            held_right_ff  <= nxt_rx_sh;
            width_right_ff <= done_width;
         end
      end else if (bck_rise) begin  // R8
         rx_sh_ff <= nxt_rx_sh;
         if (room) begin
            rx_cnt_ff <= rx_cnt_ff + 5'h01;
         end
      end
   end

   // Transmitter: each boundary loads the word held from the last frame,
   // so the MSB leaves on the next fall, one bit clock after the change.
   always @(posedge core_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         tx_sh_ff <= 18'h00000;
         dout_ff  <= 1'b0;
      end else if (boundary) begin
         tx_sh_ff <= ws_q ? held_right_ff : held_left_ff;  // R13 R5
      end else if (bck_fall) begin
         dout_ff  <= tx_sh_ff[17];  // R7 R8 R6
         tx_sh_ff <= {tx_sh_ff[16:0], 1'b0};
      end
   end

   // One stream feeds all three data pins; only the third can float.
   assign audio_data_out_1      = dout_ff;  // R11
   assign audio_data_out_2      = dout_ff;  // R11
   assign audio_data_out_3      = dout_ff;  // R11
   assign audio_data_out_1_oe_n = 1'b0;
   assign audio_data_out_2_oe_n = 1'b0;
   assign audio_data_out_3_oe_n = ~out3_ena;  // R15
   assign bit_clock_out_oe_n    = out_clk_dis;  // R14
   assign word_select_out_oe_n  = out_clk_dis;  // R14

   // Control bus watch: start, stop and busy; rate and data stability
   // are the master's duty, so a breach just shows as a start or stop.
   wire scl_q;
   wire sda_q;
   wire sda_rise;
   wire sda_fall;
   reg  scl_prev_ff;
   reg  busy_ff;
   wire start_det;
   wire stop_det;

   edge_sense u_scl (.clk(core_clk), .rst_n(rst_n_ff), .d(ctl_scl_in), .q(scl_q), .rise(), .fall());

   edge_sense u_sda (.clk(core_clk), .rst_n(rst_n_ff), .d(ctl_sda_in), .q(sda_q), .rise(sda_rise), .fall(sda_fall));

   // Clock must be high on both sides of the data edge.
   assign start_det = sda_fall & scl_q & scl_prev_ff;  // R18 R16
   assign stop_det  = sda_rise & scl_q & scl_prev_ff;  // R18 R16

   always @(posedge core_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         scl_prev_ff <= 1'b1;
         busy_ff     <= 1'b0;
      end else begin
         scl_prev_ff <= scl_q;
         if (start_det) begin
            busy_ff <= 1'b1;  // R19
         end else if (stop_det) begin
            busy_ff <= 1'b0;  // R19
         end
      end
   end

   // Sticky flags clear on a written one; a new event wins over clear.
   always @(posedge core_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         start_seen_ff <= 1'b0;
         stop_seen_ff  <= 1'b0;
      end else begin
         if (start_det) begin
            start_seen_ff <= 1'b1;
         end else if (wr_stat & wb_sel_i[1] & wb_dat_i[`ST_START_BIT]) begin
            start_seen_ff <= 1'b0;
         end
         if (stop_det) begin
            stop_seen_ff <= 1'b1;
         end else if (wr_stat & wb_sel_i[1] & wb_dat_i[`ST_STOP_BIT]) begin
            stop_seen_ff <= 1'b0;
         end
      end
   end

   // Status word assembled from live state.
   assign status = {clock_test_mode, use_div, stop_seen_ff, start_seen_ff, busy_ff,
                    width_right_ff, width_left_ff, sel_in2};

endmodule // i2s_input_switch_output

// [testbench/i2s_source_model.sv]
// Serial audio source with a free-running bit clock.
`timescale 1ns/1ps
module i2s_source_model #(
   parameter        W      = 16,          // Bits per channel word.
   parameter        HP     = 4,           // Core cycles per bit clock half period.
   parameter [23:0] BASE_L = 24'h000000,  // Left sample of frame zero.
   parameter [23:0] BASE_R = 24'h000000   // Right sample of frame zero.
) (
   input  wire       clk,                 // Core clock.
   input  wire       rst_b,               // Reset, active low.
   output reg        bck,                 // Bit clock.
   output reg        ws,                  // Word select.
   output reg        sd,                  // Serial data.
   output reg  [7:0] frm                  // Frames started.
);
   integer    ph;
   integer    slot;
   integer    s;
   reg [23:0] wd;

   // Data and word select move on the falling bit clock, giving half a bit of setup.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ph = 0;
         slot = 2 * W - 1;
         bck <= 1'b0;
         ws <= 1'b0;
         sd <= 1'b0;
         frm <= 8'h00;
      end else if (ph < HP - 1) begin
         ph = ph + 1;
      end else begin
         ph = 0;
         bck <= !bck;
         if (bck) begin
            s = (slot == 2 * W - 1) ? 0 : slot + 1;
            slot = s;
            if (s == 0) frm <= frm + 8'h01;
            wd = ((s < W) ? BASE_L : BASE_R) + {16'h0000, frm} + ((s == 0) ? 24'h000001 : 24'h000000);
            sd <= wd[(s < W) ? W - 1 - s : 2 * W - 1 - s];
            ws <= ((s + 1) % (2 * W)) >= W;
         end
      end
   end
endmodule // i2s_source_model

// [testbench/i2s_input_switch_output_assertions.sv]
// Checker for bus, routing, enables and clock path.
`timescale 1ns/1ps
`include "i2s_switch_consts.vh"
module i2s_switch_checker (
   input wire        core_clk,               // Clock.
   input wire        rst_b,                  // Reset.
   input wire        wb_cyc_i,               // Cycle.
   input wire        wb_stb_i,               // Strobe.
   input wire        wb_we_i,                // Write.
   input wire [15:0] wb_adr_i,               // Address.
   input wire [31:0] wb_dat_i,               // Write data.
   input wire [31:0] wb_dat_o,               // Read data.
   input wire        wb_ack_o,               // Ack.
   input wire        clock_divider_bypass_n, // Bypass pin.
   input wire        clock_test_mode,        // Test pin.
   input wire        internal_clock_out,     // Internal clock out.
   input wire        bit_clock_in_1,         // Input 1.
   input wire        word_select_in_1,       // Input 1.
   input wire        bit_clock_in_2,         // Input 2.
   input wire        word_select_in_2,       // Input 2.
   input wire        bit_clock_out,          // Output.
   input wire        bit_clock_out_oe_n,     // Enable.
   input wire        word_select_out,        // Output.
   input wire        word_select_out_oe_n,   // Enable.
   input wire        audio_data_out_1,       // Data.
   input wire        audio_data_out_1_oe_n,  // Enable.
   input wire        audio_data_out_2,       // Data.
   input wire        audio_data_out_3,       // Data.
   input wire        audio_data_out_3_oe_n   // Enable.
);
   reg  [15:0] ctrl_ff;
   reg  [2:0]  age_ff;
   reg  [3:0]  mode_age_ff;
   reg  [3:0]  run_ff;
   wire        ctrl_req = wb_cyc_i && wb_we_i && (wb_adr_i[15:2] == `CTRL_IDX);
   wire        ok       = (age_ff == 3'h7) && !ctrl_req;
   wire        div_mode = !clock_divider_bypass_n && !clock_test_mode;

   // Control shadow; checks pause while a write lands.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= 16'h0000;
         age_ff <= 3'h0;
         mode_age_ff <= 4'h0;
         run_ff <= 4'h0;
      end else begin
         if (ctrl_req && wb_ack_o) ctrl_ff <= wb_dat_i[15:0];
         age_ff <= (ctrl_req && wb_ack_o) ? 3'h0 : ((age_ff == 3'h7) ? age_ff : age_ff + 3'h1);
         mode_age_ff <= $changed({clock_divider_bypass_n, clock_test_mode}) ? 4'h0 :
                        ((mode_age_ff == 4'hF) ? mode_age_ff : mode_age_ff + 4'h1);
         run_ff <= $changed(internal_clock_out) ? 4'h0 : ((run_ff == 4'hF) ? run_ff : run_ff + 4'h1);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   property p_ack_next;
      s_req |=> s_ack_pulse;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack not one pulse");
   property p_ctrl_wo;
      wb_ack_o && !wb_we_i && (wb_adr_i[15:2] == `CTRL_IDX) |-> wb_dat_o == 32'h00000000;
   endproperty
   a_ctrl_wo: assert property (p_ctrl_wo) else $error("ctrl read nonzero");
   property p_bck_follow;
      ok |-> bit_clock_out == $past(ctrl_ff[`CTRL_SEL_BIT] ? bit_clock_in_2 : bit_clock_in_1);
   endproperty
   a_bck_follow: assert property (p_bck_follow) else $error("bck out wrong");
   property p_ws_follow;
      ok |-> word_select_out == $past(ctrl_ff[`CTRL_SEL_BIT] ? word_select_in_2 : word_select_in_1);
   endproperty
   a_ws_follow: assert property (p_ws_follow) else $error("ws out wrong");
   property p_clk_ws_float;
      ok |-> bit_clock_out_oe_n == ctrl_ff[`CTRL_DIS_BIT] && word_select_out_oe_n == ctrl_ff[`CTRL_DIS_BIT];
   endproperty
   a_clk_ws_float: assert property (p_clk_ws_float) else $error("clk oe wrong");
   property p_data3_enable;
      ok |-> audio_data_out_3_oe_n == !ctrl_ff[`CTRL_ENA3_BIT] && !audio_data_out_1_oe_n;
   endproperty
   a_data3_enable: assert property (p_data3_enable) else $error("data oe wrong");
   property p_same_data;
      audio_data_out_2 == audio_data_out_1 && audio_data_out_3 == audio_data_out_1;
   endproperty
   a_same_data: assert property (p_same_data) else $error("data outputs differ");
   property p_data_on_fall;
      ok && $changed(audio_data_out_1) |-> $past(bit_clock_out, 2) && !$past(bit_clock_out);
   endproperty
   a_data_on_fall: assert property (p_data_on_fall) else $error("data off bck fall");
   property p_div_even;
      div_mode && mode_age_ff == 4'hF && $changed(internal_clock_out) |-> run_ff >= 4'h7;
   endproperty
   a_div_even: assert property (p_div_even) else $error("divided clk short");
endmodule // i2s_switch_checker

bind i2s_input_switch_output i2s_switch_checker chk_u (.*);

// [testbench/i2s_input_switch_output_tb_top.sv]
// Bench for the serial audio switch.
`timescale 1ns/1ps
module i2s_input_switch_output_tb_top;
   localparam [23:0] BL1 = 24'h00A35C, BR1 = 24'h0071E2, BL2 = 24'h0B4D39, BR2 = 24'h0C2F87;
   reg         core_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i;
   reg  [15:0] wb_adr_i;
   reg  [3:0]  wb_sel_i;
   reg  [31:0] wb_dat_i, d;
   reg         clock_divider_bypass_n, clock_test_mode, ctl_scl_in, ctl_sda_in;
   reg  [2:0]  osc_cnt;
   wire        oscillator_sense_in = osc_cnt[2];
   wire [31:0] wb_dat_o;
   wire        wb_ack_o, oscillator_drive_out, internal_clock_out;
   wire        bit_clock_in_1, word_select_in_1, audio_data_in_1, bit_clock_in_2, word_select_in_2, audio_data_in_2;
   wire        bit_clock_out, bit_clock_out_oe_n, word_select_out, word_select_out_oe_n;
   wire        audio_data_out_1, audio_data_out_1_oe_n, audio_data_out_2, audio_data_out_2_oe_n;
   wire        audio_data_out_3, audio_data_out_3_oe_n;
   wire [7:0]  frm1, frm2;
   integer     failures, comparisons, rx_n, i, k, nchg, w;
   reg         src2, chk_en, pb, pws, pclk;
   reg  [23:0] sh, rx, msk, expv;

   i2s_input_switch_output dut_u (.*);
   i2s_source_model #(.W(16), .HP(4), .BASE_L(BL1), .BASE_R(BR1)) src1_u (.clk(core_clk), .rst_b(rst_b),
      .bck(bit_clock_in_1), .ws(word_select_in_1), .sd(audio_data_in_1), .frm(frm1));
   i2s_source_model #(.W(20), .HP(4), .BASE_L(BL2), .BASE_R(BR2)) src2_u (.clk(core_clk), .rst_b(rst_b),
      .bck(bit_clock_in_2), .ws(word_select_in_2), .sd(audio_data_in_2), .frm(frm2));

   // Clock and an eight-cycle oscillator.
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) osc_cnt <= osc_cnt + 3'h1;

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   // One classic cycle, held until ack is sampled high.
   task xfer(input logic we, input logic [15:0] a, input logic [3:0] sel, input logic [31:0] wd,
             output logic [31:0] rd);
      integer n;
      begin
         @(posedge core_clk);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= we;
         wb_adr_i <= a;
         wb_sel_i <= sel;
         wb_dat_i <= wd;
         n = 0;
         @(posedge core_clk);
         while (wb_ack_o !== 1'b1 && n < 16) begin
            @(posedge core_clk);
            n = n + 1;
         end
         chk("ack_seen", {31'h0, wb_ack_o}, 32'h1);
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
      end
   endtask

   task rd_chk(input string nm, input logic [15:0] a, input logic [31:0] m, input logic [31:0] exp);
      begin
         xfer(1'b0, a, 4'hF, 32'h0, d);
         chk(nm, d & m, exp);
      end
   endtask

   task rx_window(input integer warm);
      begin
         repeat (warm) @(posedge core_clk);
         rx_n = 0;
         chk_en = 1'b1;
         repeat (1000) @(posedge core_clk);
         chk_en = 1'b0;
         chk("rx_seen", {31'h0, rx_n > 2}, 32'h1);
      end
   endtask

   task wrap_up;
      begin
         $display("comparisons %0d failures %0d", comparisons, failures);
         if (failures == 0 && comparisons > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask

   // Output receiver; each word is the selected input's word one frame back.
   always @(posedge core_clk) begin
      if (bit_clock_out && !pb) begin
         if (word_select_out !== pws) begin
            rx = {sh[22:0], audio_data_out_1};
            w = src2 ? 20 : 16;
            msk = (24'h1 << w) - 24'h1;
            expv = (pws ? (src2 ? BR2 : BR1) : (src2 ? BL2 : BL1)) + {16'h0, src2 ? frm2 : frm1} - 24'h1;
            expv = expv & msk;
            if (w > 18) expv = expv & ~((24'h1 << (w - 18)) - 24'h1);
            if (chk_en) rx_n = rx_n + 1;
            if (chk_en) chk("rx_word", {8'h0, rx & msk}, {8'h0, expv});
            sh = 24'h0;
         end else begin
            sh = {sh[22:0], audio_data_out_1};
         end
         pws = word_select_out;
      end
      pb = bit_clock_out;
   end

   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge core_clk);
      failures = failures + 1;
      wrap_up;
   end

   // Test sequence.
   initial begin
      failures = 0; comparisons = 0; rx_n = 0; src2 = 1'b0; chk_en = 1'b0;
      pb = 1'b0; pws = 1'b0; sh = 24'h0; osc_cnt = 3'h0; rst_b = 1'b0;
      wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 16'h0; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
      clock_divider_bypass_n = 1'b0; clock_test_mode = 1'b0;
      ctl_scl_in = 1'b1; ctl_sda_in = 1'b1;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd_chk("ctrl_read", 16'h3FFC, 32'hFFFFFFFF, 32'h0);
      rd_chk("unmapped", 16'h0100, 32'hFFFFFFFF, 32'h0);
      rx_window(600);
      rd_chk("status_in1", 16'h0004, 32'h07FF, 32'h0420);
      xfer(1'b1, 16'h3FFC, 4'h3, 32'h0020, d);
      src2 = 1'b1;
      rx_window(900);
      rd_chk("status_in2", 16'h0004, 32'h07FF, 32'h04A5);
      xfer(1'b1, 16'h3FFC, 4'h3, 32'h20A0, d);
      repeat (3) @(posedge core_clk);
      chk("oe_float", {30'h0, bit_clock_out_oe_n, word_select_out_oe_n}, 32'h3);
      chk("oe_data3", {30'h0, audio_data_out_3_oe_n, audio_data_out_1_oe_n}, 32'h0);
      rd_chk("ctrl_wo", 16'h3FFC, 32'hFFFFFFFF, 32'h0);
      xfer(1'b1, 16'h3FFC, 4'h3, 32'h0020, d);
      repeat (3) @(posedge core_clk);
      chk("oe_drive", {29'h0, bit_clock_out_oe_n, word_select_out_oe_n, audio_data_out_3_oe_n}, 32'h1);
      // Divided, bypassed, then test position with each bypass level.
      for (i = 0; i < 4; i = i + 1) begin
         clock_divider_bypass_n <= i[0];
         clock_test_mode <= i[1];
         repeat (20) @(posedge core_clk);
         nchg = 0;
         pclk = internal_clock_out;
         for (k = 0; k < 64; k = k + 1) begin
            @(posedge core_clk);
            if (internal_clock_out !== pclk) nchg = nchg + 1;
            pclk = internal_clock_out;
         end
         chk("clk_edges", nchg, (i == 0) ? 8 : 16);
         rd_chk("clk_status", 16'h0004, 32'hC000, {16'h0, i[1], i == 0, 14'h0});
      end
      // Control bus: start, data change with clock low, then stop.
      repeat (130) @(posedge core_clk);
      ctl_sda_in <= 1'b0;
      repeat (130) @(posedge core_clk);
      ctl_scl_in <= 1'b0;
      repeat (130) @(posedge core_clk);
      ctl_sda_in <= 1'b1;
      repeat (130) @(posedge core_clk);
      ctl_sda_in <= 1'b0;
      repeat (130) @(posedge core_clk);
      rd_chk("bus_start", 16'h0004, 32'h3800, 32'h1800);
      ctl_scl_in <= 1'b1;
      repeat (130) @(posedge core_clk);
      ctl_sda_in <= 1'b1;
      repeat (130) @(posedge core_clk);
      rd_chk("bus_stop", 16'h0004, 32'h3800, 32'h3000);
      xfer(1'b1, 16'h0004, 4'h2, 32'h3000, d);
      rd_chk("bus_clear", 16'h0004, 32'h3800, 32'h0);
      wrap_up;
   end
endmodule // i2s_input_switch_output_tb_top
